/* rtl/alc_pkg.sv */
// package for the link clock and sysref control block
package alc_pkg;
    // register word offsets (byte addresses)
    localparam logic [7:0] REG_CTRL_OFF = 8'h00;
    localparam logic [7:0] REG_FRAMES_OFF = 8'h04;
    localparam logic [7:0] REG_TRIM_OFF = 8'h08;
    localparam logic [7:0] REG_STATUS_OFF = 8'h0C;
    localparam logic [7:0] REG_LINK_OFF = 8'h10;
    // control field positions
    localparam int CTRL_DIV_LSB = 0;
    localparam int CTRL_DCOFF_BIT = 2;
    localparam int CTRL_GATE_BIT = 3;
    localparam int CTRL_SROFS_BIT = 4;
    // trim field positions
    localparam int TRIM_PHASE_LSB = 0;
    localparam int TRIM_AMP_LSB = 4;
    // frames per multiframe limits and reset value
    localparam logic [5:0] FRAMES_MIN = 6'h09;
    localparam logic [5:0] FRAMES_MAX = 6'h20;
    localparam logic [5:0] FRAMES_RST = 6'h20;
    // link constants: lanes, samples, octets per frame
    localparam logic [1:0] LINK_LANES = 2'h1;
    localparam logic [1:0] LINK_SAMPLES = 2'h1;
    localparam logic [1:0] LINK_OCTETS = 2'h2;
    // alignment sequence length in multiframes
    localparam logic [2:0] ILA_MULTIFRAMES = 3'h4;
    // sync hold in frames
    localparam logic [2:0] SYNC_HOLD_FRAMES = 3'h4;
    // divider ratio codes
    typedef enum logic [1:0] {DIV_BY1, DIV_BY2, DIV_BY4, DIV_BY8} alc_div_type;
    // configuration carried as one bundle
    typedef struct packed {
        alc_div_type div;
        logic dc_offset_en;
        logic gate_en;
        logic sysref_offset_en;
        logic [3:0] phase_trim;
        logic [2:0] amp_trim;
        logic [5:0] frames;
    } alc_cfg_type;
endpackage : alc_pkg

/* rtl/alc_core.sv */
// link clock divider, frame/multiframe timing, sysref gate and register slave
// Notes on behaviour
// - one lane, one sample, two octets per frame
// - frames per multiframe 9..32, reset 32
// - sample ticks divide device clock 1/2/4/8; sample_clk_o divides it 2/2/4/8
// - divider ratio change restarts the link
// - dc offset removal bypassed until enabled
// - samples framed and sent on one lane
// - frame/multiframe timing from clock and sysref; sync re-arms alignment and gates lane_valid_o
// - non-toggling sysref is treated as idle
// - sysref anded with gate enable
// - gated-off sysref edges leave alignment unchanged
// - gate disabled after reset
// - offset and gate enables software writable
// - 4-bit phase, 3-bit amplitude trim fields
// - all settings through the register port
// - alignment sequence lasts four multiframes
`timescale 1ns/1ps
module alc_core #(
    parameter int IDLE_CYCLES = 64 // sysref quiet cycles before idle
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // link side inputs
    input wire logic sysref_i,
    input wire logic sync_n_i,
    // sample path
    input wire logic [13:0] sample_i,
    // timing and link outputs
    output logic sample_clk_o,
    output logic frame_tick_o,
    output logic mframe_tick_o,
    output logic link_reinit_o,
    output logic ila_active_o,
    output logic [15:0] lane_word_o,
    output logic lane_valid_o,
    output logic sysref_idle_o,
    output alc_pkg::alc_cfg_type cfg_o
);
    alc_pkg::alc_cfg_type cfg_q; // live configuration
    logic [7:0] div_cnt_q; // divider counter
    logic [7:0] div_len; // cycles per sample
    logic [5:0] frame_cnt_q; // frame index in multiframe
    logic sysref_q; // previous gated sysref
    logic sysref_gated; // sysref after detection gate
    logic sysref_rise; // gated rising edge
    logic [15:0] idle_cnt_q; // quiet-time counter
    logic sysref_raw_q; // previous raw sysref
    logic sample_tick; // one cycle per sample
    logic mf_end; // last frame of multiframe
    logic [2:0] ila_cnt_q; // multiframes left in alignment
    logic reinit_q; // pending restart
    logic [15:0] dc_acc_q; // dc estimate
    logic [15:0] proc_sample; // sample after dc stage
    logic wr_stb; // bus write strobe
    logic [7:0] realign_cnt_q; // count of accepted sysref edges
    // divider length from ratio code
    always_comb begin
        case (cfg_q.div)
            alc_pkg::DIV_BY1: div_len = 8'h01;
            alc_pkg::DIV_BY2: div_len = 8'h02;
            alc_pkg::DIV_BY4: div_len = 8'h04;
            alc_pkg::DIV_BY8: div_len = 8'h08;
            default: div_len = 8'h01;
        endcase
    end
    // detection gate: raw sysref only passes with gate on
    assign sysref_gated = sysref_i & cfg_q.gate_en;
    assign sysref_rise = sysref_gated & ~sysref_q;
    assign sample_tick = (div_cnt_q == div_len - 8'h01);
    // compare with >= so a smaller count written mid-multiframe cannot let the counter run past it
    assign mf_end = sample_tick && (frame_cnt_q >= cfg_q.frames - 6'h01);
    assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    // register writes; ratio change flags a restart
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= '{div: alc_pkg::DIV_BY1, dc_offset_en: 1'b0, gate_en: 1'b0,
                       sysref_offset_en: 1'b0, phase_trim: 4'h0, amp_trim: 3'h0,
                       frames: alc_pkg::FRAMES_RST};
            reinit_q <= 1'b0;
        end else begin
            reinit_q <= 1'b0;
            if (wr_stb && wb_sel_i[0]) begin
                case (wb_adr_i)
                    alc_pkg::REG_CTRL_OFF: begin
                        cfg_q.div <= alc_pkg::alc_div_type'(wb_dat_i[alc_pkg::CTRL_DIV_LSB +: 2]);
                        cfg_q.dc_offset_en <= wb_dat_i[alc_pkg::CTRL_DCOFF_BIT];
                        cfg_q.gate_en <= wb_dat_i[alc_pkg::CTRL_GATE_BIT];
                        cfg_q.sysref_offset_en <= wb_dat_i[alc_pkg::CTRL_SROFS_BIT];
                        // only a real ratio change restarts the link
                        if (wb_dat_i[alc_pkg::CTRL_DIV_LSB +: 2] != cfg_q.div) begin
                            reinit_q <= 1'b1;
                        end
                    end
                    alc_pkg::REG_FRAMES_OFF: begin
                        // out of range values are clamped, never stored
                        if ((|wb_dat_i[31:6]) || wb_dat_i[5:0] > alc_pkg::FRAMES_MAX) begin
                            cfg_q.frames <= alc_pkg::FRAMES_MAX;
                        end else if (wb_dat_i[5:0] < alc_pkg::FRAMES_MIN) begin
                            cfg_q.frames <= alc_pkg::FRAMES_MIN;
                        end else begin
                            cfg_q.frames <= wb_dat_i[5:0];
                        end
                    end
                    alc_pkg::REG_TRIM_OFF: begin
                        cfg_q.phase_trim <= wb_dat_i[alc_pkg::TRIM_PHASE_LSB +: 4];
                        cfg_q.amp_trim <= wb_dat_i[alc_pkg::TRIM_AMP_LSB +: 3];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
    // bus answer: one-cycle ack, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= 32'h0000_0000;
            if (wb_cyc_i && wb_stb_i && !wb_we_i) begin
                case (wb_adr_i)
                    alc_pkg::REG_CTRL_OFF: wb_dat_o <= {27'h000_0000, cfg_q.sysref_offset_en, cfg_q.gate_en,
                                                        cfg_q.dc_offset_en, cfg_q.div};
                    alc_pkg::REG_FRAMES_OFF: wb_dat_o <= {26'h000_0000, cfg_q.frames};
                    alc_pkg::REG_TRIM_OFF: wb_dat_o <= {25'h000_0000, cfg_q.amp_trim, cfg_q.phase_trim};
                    alc_pkg::REG_STATUS_OFF: wb_dat_o <= {16'h0000, realign_cnt_q, 4'h0, sync_n_i,
                                                          ila_active_o, sysref_idle_o, sysref_i};
                    alc_pkg::REG_LINK_OFF: wb_dat_o <= {26'h000_0000, alc_pkg::LINK_OCTETS,
                                                        alc_pkg::LINK_SAMPLES, alc_pkg::LINK_LANES};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
    // sampling clock divider
    always_ff @(posedge clk_i) begin
        if (rst_i || reinit_q) begin
            div_cnt_q <= 8'h00;
            sample_clk_o <= 1'b0;
        end else begin
            div_cnt_q <= sample_tick ? 8'h00 : div_cnt_q + 8'h01;
            sample_clk_o <= (cfg_q.div == alc_pkg::DIV_BY1) ? ~sample_clk_o
                            : (div_cnt_q < (div_len >> 1)) ? 1'b0 : 1'b1;
        end
    end
    // frame and multiframe counters; frame equals sample with one sample per frame
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_cnt_q <= 6'h00;
            sysref_q <= 1'b0;
            frame_tick_o <= 1'b0;
            mframe_tick_o <= 1'b0;
            realign_cnt_q <= 8'h00;
        end else begin
            sysref_q <= sysref_gated;
            frame_tick_o <= sample_tick;
            mframe_tick_o <= mf_end;
            if (sysref_rise) begin
                frame_cnt_q <= 6'h00;
                realign_cnt_q <= realign_cnt_q + 8'h01;
            end else if (mf_end) begin
                frame_cnt_q <= 6'h00;
            end else if (sample_tick) begin
                frame_cnt_q <= frame_cnt_q + 6'h01;
            end
        end
    end
    // sysref idle detection on the raw input
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sysref_raw_q <= 1'b0;
            idle_cnt_q <= 16'h0000;
            sysref_idle_o <= 1'b1;
        end else begin
            sysref_raw_q <= sysref_i;
            if (sysref_i != sysref_raw_q) begin
                idle_cnt_q <= 16'h0000;
                sysref_idle_o <= 1'b0;
            end else if (idle_cnt_q == 16'(IDLE_CYCLES - 1)) begin
                sysref_idle_o <= 1'b1;
            end else begin
                idle_cnt_q <= idle_cnt_q + 16'h0001;
            end
        end
    end
    // link start: sync low or restart re-arms four multiframes of alignment
    always_ff @(posedge clk_i) begin
        if (rst_i || reinit_q || !sync_n_i) begin
            ila_cnt_q <= alc_pkg::ILA_MULTIFRAMES;
            ila_active_o <= 1'b1;
            link_reinit_o <= rst_i ? 1'b0 : reinit_q;
        end else begin
            link_reinit_o <= 1'b0;
            if (mf_end && ila_cnt_q != 3'h0) begin
                ila_cnt_q <= ila_cnt_q - 3'h1;
                ila_active_o <= (ila_cnt_q != 3'h1);
            end
        end
    end
    // dc offset removal: leaky estimate subtracted only when enabled
    assign proc_sample = cfg_q.dc_offset_en ? ({{2{sample_i[13]}}, sample_i} - dc_acc_q)
                                            : {{2{sample_i[13]}}, sample_i};
    always_ff @(posedge clk_i) begin
        if (rst_i || !cfg_q.dc_offset_en) begin
            dc_acc_q <= 16'h0000;
        end else if (sample_tick) begin
            dc_acc_q <= dc_acc_q + {{6{proc_sample[15]}}, proc_sample[15:6]};
        end
    end
    // lane output: two octets per frame, one lane
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lane_word_o <= 16'h0000;
            lane_valid_o <= 1'b0;
            cfg_o <= '0;
        end else begin
            lane_valid_o <= sample_tick && !ila_active_o && sync_n_i;
            if (sample_tick) begin
                lane_word_o <= {proc_sample[13:0], 2'b00};
            end
            cfg_o <= cfg_q;
        end
    end
    // gated edge must realign: counter at zero the cycle after
    property p_realign;
        @(posedge clk_i) disable iff (rst_i)
        sysref_rise |=> (frame_cnt_q == 6'h00);
    endproperty
    a_realign: assert property (p_realign) else $error("sysref edge did not realign");
    // gate off: a sysref level leaves the counter to advance by frames only
    property p_gate_block;
        @(posedge clk_i) disable iff (rst_i)
        (!cfg_q.gate_en && sysref_i && !mf_end)
            |=> (frame_cnt_q == $past(frame_cnt_q) + {5'h00, $past(sample_tick)});
    endproperty
    a_gate_block: assert property (p_gate_block) else $error("sysref passed closed gate");
    // frames stay in range
    property p_frames_range;
        @(posedge clk_i) disable iff (rst_i)
        cfg_q.frames >= alc_pkg::FRAMES_MIN && cfg_q.frames <= alc_pkg::FRAMES_MAX;
    endproperty
    a_frames_range: assert property (p_frames_range) else $error("frames out of range");
    // ratio change leads to restart pulse one cycle on
    property p_reinit;
        @(posedge clk_i) disable iff (rst_i)
        (cfg_q.div != $past(cfg_q.div)) |=> link_reinit_o;
    endproperty
    a_reinit: assert property (p_reinit) else $error("ratio change without restart");
    // divide by four: no sample tick in the three cycles after one
    property p_div;
        @(posedge clk_i) disable iff (rst_i || reinit_q)
        (sample_tick && cfg_q.div == alc_pkg::DIV_BY4 && $stable(cfg_q.div)) |=> !sample_tick [*3];
    endproperty
    a_div: assert property (p_div) else $error("divide by four period wrong");
    // dc stage bypass
    property p_dc_bypass;
        @(posedge clk_i) disable iff (rst_i)
        !cfg_q.dc_offset_en |-> proc_sample[13:0] == sample_i;
    endproperty
    a_dc_bypass: assert property (p_dc_bypass) else $error("dc stage not bypassed");
    // no lane data during alignment
    property p_ila_quiet;
        @(posedge clk_i) disable iff (rst_i)
        ila_active_o |=> !lane_valid_o;
    endproperty
    a_ila_quiet: assert property (p_ila_quiet) else $error("data during alignment");
    // multiframe tick comes in the same cycle as a frame tick
    property p_mframe;
        @(posedge clk_i) disable iff (rst_i)
        mframe_tick_o |-> frame_tick_o;
    endproperty
    a_mframe: assert property (p_mframe) else $error("multiframe not on frame");
    // every taken request is answered once, the next cycle
    sequence s_bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    property p_ack_once;
        @(posedge clk_i) disable iff (rst_i)
        s_bus_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("bus answer not a single pulse");
    // a taken trim write lands at the edge it is taken
    property p_trim_write;
        @(posedge clk_i) disable iff (rst_i)
        s_bus_req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == alc_pkg::REG_TRIM_OFF)
            |=> cfg_q.phase_trim == $past(wb_dat_i[alc_pkg::TRIM_PHASE_LSB +: 4]);
    endproperty
    a_trim_write: assert property (p_trim_write) else $error("trim write lost");
    // sync released: alignment is armed at that edge
    sequence s_sync_release;
        !sync_n_i ##1 sync_n_i;
    endsequence
    property p_ila_rearm;
        @(posedge clk_i) disable iff (rst_i)
        s_sync_release |-> ila_active_o;
    endproperty
    a_ila_rearm: assert property (p_ila_rearm) else $error("alignment not armed on sync release");
    // the last multiframe of alignment closes it
    property p_ila_end;
        @(posedge clk_i) disable iff (rst_i)
        (ila_cnt_q == 3'h1 && mf_end && sync_n_i && !reinit_q) |=> !ila_active_o;
    endproperty
    a_ila_end: assert property (p_ila_end) else $error("alignment overran");
    // with the dc stage off the lane word carries the raw sample
    property p_lane_word;
        @(posedge clk_i) disable iff (rst_i)
        (!cfg_q.dc_offset_en && sample_tick) |=> lane_word_o == {$past(sample_i), 2'b00};
    endproperty
    a_lane_word: assert property (p_lane_word) else $error("lane word differs from sample");
    // any raw sysref change clears the idle flag next cycle
    property p_idle_clear;
        @(posedge clk_i) disable iff (rst_i)
        (sysref_i != sysref_raw_q) |=> !sysref_idle_o;
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("idle flag kept on toggle");
    // a full quiet window sets the idle flag
    property p_idle_set;
        @(posedge clk_i) disable iff (rst_i)
        (sysref_i == sysref_raw_q && idle_cnt_q == 16'(IDLE_CYCLES - 1)) |=> sysref_idle_o;
    endproperty
    a_idle_set: assert property (p_idle_set) else $error("idle flag not set after quiet window");
    // a restart always re-arms alignment
    property p_reinit_arms;
        @(posedge clk_i) disable iff (rst_i)
        link_reinit_o |-> ila_active_o;
    endproperty
    a_reinit_arms: assert property (p_reinit_arms) else $error("restart without alignment");
    // gate is closed as reset is released
    property p_gate_reset;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> !cfg_q.gate_en;
    endproperty
    a_gate_reset: assert property (p_gate_reset) else $error("gate open after reset");
endmodule : alc_core

/* dv/alc_rx_model.sv */
// receiver-side model driving the sync request and sysref
`timescale 1ns/1ps
module alc_rx_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // requests from the bench
    input wire logic resync_i,
    input wire logic pulse_i,
    // frame timing seen from the device
    input wire logic frame_tick_i,
    // link outputs
    output logic sysref_o,
    output logic sync_n_o
);
    logic [2:0] hold_q; // frames still to hold sync low
    logic [1:0] pulse_q; // sysref high cycles left
    // sync low until the fourth frame tick, then released
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_q <= 3'h0;
            sync_n_o <= 1'b1;
        end else if (resync_i) begin
            hold_q <= 3'h4;
            sync_n_o <= 1'b0;
        end else if (hold_q != 3'h0 && frame_tick_i) begin
            hold_q <= hold_q - 3'h1;
            sync_n_o <= (hold_q == 3'h1);
        end
    end
    // one short pulse per request, idle low between them
    always_ff @(posedge clk_i) begin
        if (rst_i) pulse_q <= 2'h0;
        else if (pulse_i) pulse_q <= 2'h2;
        else if (pulse_q != 2'h0) pulse_q <= pulse_q - 2'h1;
    end
    assign sysref_o = (pulse_q != 2'h0);
endmodule : alc_rx_model

/* dv/tb_adc_link_clock_sysref_control.sv */
// self-checking bench for the link clock and sysref control block
`timescale 1ns/1ps
module tb_adc_link_clock_sysref_control;
    localparam int IDLE_N = 8; // short quiet window keeps the run brief
    localparam int W_FT = 0, W_MT = 1, W_RI = 2, W_ID = 3, W_LV = 4, W_SN = 5, W_IA = 6;
    logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, sysref, sync_n, resync, pulse;
    logic ftick, mtick, reinit, ila, lvalid, idle, sclk;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, q;
    logic [13:0] sample;
    logic [15:0] lword;
    logic [6:0] obs; // watched outputs, indexed by W_ codes
    alc_pkg::alc_cfg_type cfg;
    int bad_count, samples_checked, n;
    assign obs = {ila, sync_n, lvalid, idle, reinit, mtick, ftick};
    alc_core #(.IDLE_CYCLES(IDLE_N)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
        .wb_ack_o(wb_ack), .sysref_i(sysref), .sync_n_i(sync_n), .sample_i(sample), .sample_clk_o(sclk),
        .frame_tick_o(ftick), .mframe_tick_o(mtick), .link_reinit_o(reinit), .ila_active_o(ila),
        .lane_word_o(lword), .lane_valid_o(lvalid), .sysref_idle_o(idle), .cfg_o(cfg));
    alc_rx_model i_rx (.clk_i(clk_i), .rst_i(rst_i), .resync_i(resync), .pulse_i(pulse), .frame_tick_i(ftick),
        .sysref_o(sysref), .sync_n_o(sync_n));
    // one counted comparison
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // verdict and end of run
    task automatic stop_test();
        if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    // classic cycle held until ack is sampled; data taken at that edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat_w <= d;
        await(-1, 1'b1, 20);
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : bus
    // bounded wait for an output level; running out ends the run
    task automatic await(input int s, input logic v, input int lim);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (((s < 0) ? wb_ack : obs[s]) !== v && n < lim);
        if (((s < 0) ? wb_ack : obs[s]) !== v) begin
            check("wait", 32'(v), ~32'(v));
            stop_test();
        end
    endtask : await
    // cycles between two ticks of one kind
    task automatic gap(input int s, input logic [31:0] exp, input string what);
        await(s, 1'b1, 400);
        await(s, 1'b1, 400);
        check(what, exp, 32'(n));
    endtask : gap
    // one sysref request to the partner
    task automatic fire();
        pulse <= 1'b1;
        @(posedge clk_i);
        pulse <= 1'b0;
    endtask : fire
    // reset state, fixed link shape, unmapped read
    task automatic t_reset();
        repeat (2) @(posedge clk_i);
        check("frames", 32'h0000_0020, 32'(cfg.frames));
        check("gate", 32'h0000_0000, 32'(cfg.gate_en));
        check("dc offset", 32'h0000_0000, 32'(cfg.dc_offset_en));
        bus(1'b0, alc_pkg::REG_LINK_OFF, 32'h0000_0000);
        check("link shape", 32'h0000_0025, q);
        bus(1'b0, 8'h20, 32'h0000_0000);
        check("unmapped", 32'h0000_0000, q);
    endtask : t_reset
    // frames count clamped to 9..32; trim field widths
    task automatic t_fields();
        logic [31:0] wv[4] = '{32'h0000_0005, 32'h0000_0009, 32'h0000_0014, 32'h0000_0028};
        logic [31:0] ev[4] = '{32'h0000_0009, 32'h0000_0009, 32'h0000_0014, 32'h0000_0020};
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, alc_pkg::REG_FRAMES_OFF, wv[i]);
            bus(1'b0, alc_pkg::REG_FRAMES_OFF, 32'h0000_0000);
            check("frames", ev[i], q);
        end
        bus(1'b1, alc_pkg::REG_TRIM_OFF, 32'h0000_00FF);
        bus(1'b0, alc_pkg::REG_TRIM_OFF, 32'h0000_0000);
        check("trim", 32'h0000_007F, q);
        bus(1'b1, alc_pkg::REG_TRIM_OFF, 32'h0000_0035);
        @(posedge clk_i);
        check("phase", 32'h0000_0005, 32'(cfg.phase_trim));
        check("amplitude", 32'h0000_0003, 32'(cfg.amp_trim));
    endtask : t_fields
    // every ratio: restart pulse, frame and multiframe periods
    task automatic t_div();
        int k;
        bus(1'b1, alc_pkg::REG_FRAMES_OFF, 32'h0000_0009);
        for (int c = 3; c >= 0; c--) begin
            bus(1'b1, alc_pkg::REG_CTRL_OFF, 32'(c));
            await(W_RI, 1'b1, 6);
            gap(W_FT, 32'(1 << c), "frame period");
            gap(W_MT, 32'(9 << c), "multiframe period");
            // two sample periods hold exactly one ratio worth of high cycles
            k = 0;
            repeat (2 << c) begin
                @(posedge clk_i);
                if (sclk === 1'b1) k++;
            end
            check("sample clock high", 32'(1 << c), 32'(k));
            // read the new ratio back after the restart and period checks
            bus(1'b0, alc_pkg::REG_CTRL_OFF, 32'h0000_0000);
            check("ratio", 32'(c), 32'(q[1:0]));
        end
        bus(1'b1, alc_pkg::REG_CTRL_OFF, 32'h0000_0014);
        @(posedge clk_i);
        check("dc offset", 32'h0000_0001, 32'(cfg.dc_offset_en));
        check("sysref offset", 32'h0000_0001, 32'(cfg.sysref_offset_en));
    endtask : t_div
    // sysref ignored while gated, realigns once the gate opens
    task automatic t_gate();
        logic [31:0] c0;
        int k;
        bus(1'b0, alc_pkg::REG_STATUS_OFF, 32'h0000_0000);
        c0 = 32'(q[15:8]);
        check("idle", 32'h0000_0001, 32'(idle));
        fire();
        await(W_ID, 1'b0, 6);
        bus(1'b0, alc_pkg::REG_STATUS_OFF, 32'h0000_0000);
        check("gated realigns", c0, 32'(q[15:8]));
        bus(1'b1, alc_pkg::REG_CTRL_OFF, 32'h0000_0008);
        fire();
        // last multiframe tick in the window: model delay, counter reset edge, nine frames, registered tick
        k = 0;
        for (int i = 1; i <= 11; i++) begin
            @(posedge clk_i);
            if (mtick === 1'b1) k = i;
        end
        check("realign to multiframe", 32'h0000_000B, 32'(k));
        bus(1'b0, alc_pkg::REG_STATUS_OFF, 32'h0000_0000);
        check("realigns", 32'(c0[7:0] + 8'h01), 32'(q[15:8]));
        gap(W_MT, 32'h0000_0009, "realigned multiframe");
        await(W_ID, 1'b1, 30);
    endtask : t_gate
    // resync: alignment of four multiframes, then live lane words
    task automatic t_sync();
        int k;
        resync <= 1'b1;
        @(posedge clk_i);
        resync <= 1'b0;
        await(W_SN, 1'b0, 4);
        await(W_SN, 1'b1, 40);
        check("sync hold", 32'(alc_pkg::SYNC_HOLD_FRAMES), 32'(n));
        check("alignment armed", 32'h0000_0001, 32'(ila));
        k = 0;
        repeat (200) begin
            @(posedge clk_i);
            // the tick that ends alignment arrives together with ila low
            if (mtick === 1'b1) k++;
            if (ila !== 1'b1) break;
        end
        check("alignment multiframes", 32'h0000_0004, 32'(k));
        await(W_LV, 1'b1, 20);
        check("lane word", {16'h0000, sample, 2'b00}, {16'h0000, lword});
    endtask : t_sync
    // free-running clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // main sequence
    initial begin
        {rst_i, wb_cyc, wb_stb, wb_we, resync, pulse} = 6'b10_0000;
        wb_adr = 8'h00;
        wb_sel = 4'hF;
        wb_dat_w = 32'h0000_0000;
        sample = 14'h1A5C;
        bad_count = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_fields();
        t_div();
        t_gate();
        t_sync();
        stop_test();
    end
endmodule : tb_adc_link_clock_sysref_control
